// ==== logic/scr_dev.sv ====
/*
 * Serial configuration register bank of the converter: frame decoder,
 * streaming address stepping, register file, soft reset and user-side
 * control outputs.
 * Assumes sclk, cs_n and sdi are synchronous to hclk and that each
 * sclk level lasts at least two hclk cycles.
 */
// Design decision made here: register access over AHB-Lite.
// What this block does
// - writing config bit 7 resets whole chip
// - soft reset bit clears itself when done
// - host waits 750ns after soft reset
// - ascend bit picks increment or decrement
// - indicator reads one; reads on sdo only
// - host writes reserved fields with defaults
// - mode code three powers down device
// - maker code register is fixed, read-only
// - hold bit freezes streaming address
// - receiver enable switches sysref receiver on
// - processor enable lets sysref events act
// - host enables receiver before processor
// - fine step bit shrinks sysref delays
// - delay choice field picks capture delay
// - config register resets to 0x30
`timescale 1ns/1ps
module scr_dev
    import scr_pkg::*;
#(
    // arbitrary neutral value
    parameter logic [15:0] MAKER_CODE = 16'h5a3c
) (
    // serial link
    scr_spi_if.dev    spi,
    // clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // sysref
    input  wire logic sysref_in,
    output logic      sysref_event,
    output logic      sysref_receiver_enable,
    output logic      sysref_processor_enable,
    output logic      sysref_fine_step,
    output logic [3:0] sysref_delay_choice,
    // device control
    output logic      chip_reset,
    output logic      power_down,
    output logic [2:0] clock_input_options
);
    logic        sclk_q;
    logic [4:0]  cnt_q;
    logic [14:0] sh_q;
    logic [14:0] addr_q;
    logic        rw_q;
    logic        load_q;
    logic [7:0]  out_sh_q;
    logic        sdo_q;
    logic [7:0]  cfg_q;
    logic [7:0]  opmode_q;
    logic [7:0]  stream_q;
    logic [7:0]  sysref_q;
    logic [7:0]  clkopt_q;
    logic        chip_reset_q;
    logic        power_down_q;
    logic        recv_en_q;
    logic        proc_en_q;
    logic        fine_q;
    logic [3:0]  choice_q;
    logic [2:0]  clkopt_out_q;
    logic        sysref_prev_q;
    logic        sysref_event_q;

    logic        rise;
    logic        fall;
    logic        active;
    logic        rst_busy;
    logic        rst_active;
    logic        soft_start;
    logic        wr_en;
    logic [7:0]  wbyte;
    logic [7:0]  rdata;
    logic [14:0] addr_step;
    logic        sysref_seen;

    assign rise       = spi.sclk & ~sclk_q;
    assign fall       = ~spi.sclk & sclk_q;
    assign active     = ~spi.cs_n & ~rst_busy;
    assign wbyte      = {sh_q[6:0], spi.sdi};
    assign wr_en      = active & rise & (cnt_q == FRAME_LAST) & ~rw_q;
    assign soft_start = wr_en & (addr_q == ADDR_SERIAL_CFG)
                      & wbyte[CFG_SOFT_RESET_BIT];
    assign rst_active = soft_start | rst_busy;

    // settling interval of the soft reset
    scr_timer #(
        .COUNT (DEV_RESET_CYC)
    ) u_reset_timer (
        .hclk    (hclk),
        .hresetn (hresetn),
        .start   (soft_start),
        .busy    (rst_busy)
    );

    always_comb begin
        if (stream_q[STREAM_HOLD_BIT]) begin
            addr_step = addr_q;
        end else if (cfg_q[CFG_ASCEND_BIT]) begin
            addr_step = addr_q + 15'h0001;
        end else begin
            addr_step = addr_q - 15'h0001;
        end
    end

    always_comb begin
        rdata = 8'h00;
        case (addr_q)
            ADDR_SERIAL_CFG: begin
                rdata = cfg_q;
                rdata[CFG_SOFT_RESET_BIT] = rst_busy;
                rdata[CFG_SEP_OUT_BIT]    = 1'b1;
            end
            ADDR_OPMODE:   rdata = opmode_q;
            ADDR_MAKER_LO: rdata = MAKER_CODE[7:0];
            ADDR_MAKER_HI: rdata = MAKER_CODE[15:8];
            ADDR_STREAM:   rdata = stream_q;
            ADDR_SYSREF:   rdata = sysref_q;
            ADDR_CLKOPT:   rdata = clkopt_q;
            default:       rdata = 8'h00;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sclk_q <= 1'b0;
        end else begin
            sclk_q <= spi.sclk;
        end
    end

    // frame decode: header then repeating data bytes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q  <= 5'h00;
            sh_q   <= 15'h0000;
            addr_q <= 15'h0000;
            rw_q   <= 1'b0;
            load_q <= 1'b0;
        end else if (!active) begin
            cnt_q  <= 5'h00;
            load_q <= 1'b0;
        end else if (rise) begin
            sh_q <= {sh_q[13:0], spi.sdi};
            if (cnt_q == HDR_LAST) begin
                addr_q <= {sh_q[13:0], spi.sdi};
                rw_q   <= sh_q[14];
                load_q <= 1'b1;
                cnt_q  <= DATA_FIRST;
            end else if (cnt_q == FRAME_LAST) begin
                addr_q <= addr_step;
                load_q <= 1'b1;
                cnt_q  <= DATA_FIRST;
            end else begin
                cnt_q <= cnt_q + 5'h01;
            end
        end else if (fall) begin
            load_q <= 1'b0;
        end
    end

    // read data leaves on the separate output, msb first
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            out_sh_q <= 8'h00;
            sdo_q    <= 1'b0;
        end else if (!active) begin
            out_sh_q <= 8'h00;
            sdo_q    <= 1'b0;
        end else if (fall && load_q) begin
            sdo_q    <= rdata[7];
            out_sh_q <= {rdata[6:0], 1'b0};
        end else if (fall && cnt_q >= DATA_FIRST) begin
            sdo_q    <= out_sh_q[7];
            out_sh_q <= {out_sh_q[6:0], 1'b0};
        end
    end

    // register file; soft reset holds every register at its reset value
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_q    <= RST_SERIAL_CFG;
            opmode_q <= RST_OPMODE;
            stream_q <= RST_STREAM;
            sysref_q <= RST_SYSREF;
            clkopt_q <= RST_CLKOPT;
        end else if (rst_active) begin
            cfg_q    <= RST_SERIAL_CFG;
            opmode_q <= RST_OPMODE;
            stream_q <= RST_STREAM;
            sysref_q <= RST_SYSREF;
            clkopt_q <= RST_CLKOPT;
        end else if (wr_en) begin
            case (addr_q)
                ADDR_SERIAL_CFG: cfg_q    <= wbyte & RSV_SERIAL_CFG
                                           | 8'h20 & wbyte;
                ADDR_OPMODE:     opmode_q <= wbyte;
                ADDR_STREAM:     stream_q <= wbyte;
                ADDR_SYSREF:     sysref_q <= wbyte;
                ADDR_CLKOPT:     clkopt_q <= wbyte;
                default:         cfg_q    <= cfg_q;
            endcase
        end
    end

    assign sysref_seen = sysref_in & recv_en_q;

    // user-side controls
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            chip_reset_q   <= 1'b0;
            power_down_q   <= 1'b0;
            recv_en_q      <= 1'b0;
            proc_en_q      <= 1'b0;
            fine_q         <= 1'b0;
            choice_q       <= 4'h0;
            clkopt_out_q   <= 3'h0;
            sysref_prev_q  <= 1'b0;
            sysref_event_q <= 1'b0;
        end else begin
            chip_reset_q   <= rst_active;
            power_down_q   <= (opmode_q[1:0] == MODE_POWER_DOWN);
            recv_en_q      <= sysref_q[SYS_RECV_BIT];
            proc_en_q      <= sysref_q[SYS_PROC_BIT];
            fine_q         <= sysref_q[SYS_FINE_BIT];
            choice_q       <= sysref_q[3:0];
            clkopt_out_q   <= clkopt_q[2:0];
            sysref_prev_q  <= sysref_seen;
            sysref_event_q <= proc_en_q & sysref_seen
                            & ~sysref_prev_q;
        end
    end

    assign spi.sdo                 = sdo_q;
    assign chip_reset              = chip_reset_q;
    assign power_down              = power_down_q;
    assign sysref_receiver_enable  = recv_en_q;
    assign sysref_processor_enable = proc_en_q;
    assign sysref_fine_step        = fine_q;
    assign sysref_delay_choice     = choice_q;
    assign clock_input_options     = clkopt_out_q;
    assign sysref_event            = sysref_event_q;
endmodule

// ==== logic/scr_host.sv ====
/*
 * Host controller for the serial register bank: AHB-Lite slave with a
 * command and a status register, and a serial master issuing one
 * single-byte frame per command.
 * Assumes a single AHB-Lite slave whose hreadyout is the bus hready.
 */
`timescale 1ns/1ps
module scr_host
    import scr_pkg::*;
(
    // serial link
    scr_spi_if.host    spi,
    // clock and reset
    input  wire logic  hclk,
    input  wire logic  hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp
);
    scr_host_state_t state_q;
    logic        dp_wr_q;
    logic [7:0]  dp_ofs_q;
    logic [31:0] hrdata_q;
    logic        hreadyout_q;
    logic [23:0] tx_q;
    logic [7:0]  rx_q;
    logic [1:0]  div_q;
    logic [4:0]  bit_q;
    logic [7:0]  settle_q;
    logic        soft_q;
    logic        recv_shadow_q;
    logic        sclk_q;
    logic        cs_n_q;
    logic        sdi_q;

    logic        cmd_we;
    logic        cmd_read;
    logic [14:0] cmd_addr;
    logic [7:0]  cmd_data;
    logic [31:0] status;

    // force reserved fields to their defaults
    function automatic logic [7:0] fix_rsv(input logic [14:0] a,
                                           input logic [7:0]  d);
        logic [7:0] m;
        logic [7:0] r;
        m = 8'h00;
        r = 8'h00;
        case (a)
            ADDR_SERIAL_CFG: begin m = RSV_SERIAL_CFG; r = RST_SERIAL_CFG; end
            ADDR_OPMODE:     begin m = RSV_OPMODE;     r = RST_OPMODE;     end
            ADDR_STREAM:     begin m = RSV_STREAM;     r = RST_STREAM;     end
            ADDR_SYSREF:     begin m = RSV_SYSREF;     r = RST_SYSREF;     end
            ADDR_CLKOPT:     begin m = RSV_CLKOPT;     r = RST_CLKOPT;     end
            default:         begin m = 8'h00;          r = 8'h00;          end
        endcase
        return (d & ~m) | (r & m);
    endfunction

    assign cmd_we   = dp_wr_q & (dp_ofs_q == HOST_CMD_OFS)
                    & (state_q == HS_IDLE);
    assign cmd_read = hwdata[CMD_READ_BIT];
    assign cmd_addr = hwdata[CMD_ADDR_LSB +: 15];

    always_comb begin
        cmd_data = 8'h00;
        if (!cmd_read) begin
            cmd_data = fix_rsv(cmd_addr, hwdata[7:0]);
        end
        if (cmd_addr == ADDR_SYSREF && !recv_shadow_q) begin
            cmd_data[SYS_PROC_BIT] = 1'b0;
        end
    end

    always_comb begin
        status = 32'h0000_0000;
        status[STAT_BUSY_BIT]   = (state_q != HS_IDLE);
        status[STAT_SETTLE_BIT] = (state_q == HS_SETTLE);
        status[STAT_RDATA_LSB +: 8] = rx_q;
    end

    // bus slave, zero wait states
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr_q     <= 1'b0;
            dp_ofs_q    <= 8'h00;
            hrdata_q    <= 32'h0000_0000;
            hreadyout_q <= 1'b1;
        end else begin
            hreadyout_q <= 1'b1;
            dp_wr_q     <= hsel & hready & htrans[1] & hwrite;
            dp_ofs_q    <= haddr[7:0];
            if (hsel && hready && htrans[1] && !hwrite) begin
                hrdata_q <= (haddr[7:0] == HOST_STAT_OFS) ? status
                                                           : 32'h0000_0000;
            end
        end
    end

    // serial master
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q       <= HS_IDLE;
            tx_q          <= 24'h00_0000;
            rx_q          <= 8'h00;
            div_q         <= 2'h0;
            bit_q         <= 5'h00;
            settle_q      <= 8'h00;
            soft_q        <= 1'b0;
            recv_shadow_q <= 1'b0;
            sclk_q        <= 1'b0;
            cs_n_q        <= 1'b1;
            sdi_q         <= 1'b0;
        end else begin
            case (state_q)
                HS_IDLE: begin
                    if (cmd_we) begin
                        tx_q    <= {cmd_read, cmd_addr, cmd_data};
                        sdi_q   <= cmd_read;
                        cs_n_q  <= 1'b0;
                        div_q   <= 2'h0;
                        bit_q   <= 5'h00;
                        soft_q  <= ~cmd_read & (cmd_addr == ADDR_SERIAL_CFG)
                                 & cmd_data[CFG_SOFT_RESET_BIT];
                        if (!cmd_read && cmd_addr == ADDR_SYSREF) begin
                            recv_shadow_q <= cmd_data[SYS_RECV_BIT];
                        end
                        state_q <= HS_SHIFT;
                    end
                end
                HS_SHIFT: begin
                    div_q <= div_q + 2'h1;
                    if (div_q == 2'(SCLK_HALF_CYC - 1)) begin
                        div_q  <= 2'h0;
                        sclk_q <= ~sclk_q;
                        if (!sclk_q) begin
                            rx_q <= {rx_q[6:0], spi.sdo};
                        end else if (bit_q == FRAME_LAST) begin
                            cs_n_q   <= 1'b1;
                            settle_q <= 8'h00;
                            state_q  <= soft_q ? HS_SETTLE : HS_IDLE;
                        end else begin
                            bit_q <= bit_q + 5'h01;
                            tx_q  <= {tx_q[22:0], 1'b0};
                            sdi_q <= tx_q[22];
                        end
                    end
                end
                HS_SETTLE: begin
                    recv_shadow_q <= 1'b0;
                    settle_q      <= settle_q + 8'h01;
                    if (settle_q == 8'(HOST_SETTLE_CYC - 1)) begin
                        state_q <= HS_IDLE;
                    end
                end
                default: state_q <= HS_IDLE;
            endcase
        end
    end

    assign hreadyout = hreadyout_q;
    assign hrdata    = hrdata_q;
    assign hresp     = 1'b0;
    assign spi.sclk  = sclk_q;
    assign spi.cs_n  = cs_n_q;
    assign spi.sdi   = sdi_q;
endmodule

// ==== logic/scr_pkg.sv ====
/*
 * Shared constants for the serial configuration register bank and its
 * host controller: register map, field positions, reset values, frame
 * layout, timing counts and host-side register offsets.
 * Assumes a single 250 MHz system clock on both ends.
 */
package scr_pkg;

    // register addresses on the serial link
    localparam logic [14:0] ADDR_SERIAL_CFG = 15'h0000;
    localparam logic [14:0] ADDR_OPMODE     = 15'h0002;
    localparam logic [14:0] ADDR_MAKER_LO   = 15'h000c;
    localparam logic [14:0] ADDR_MAKER_HI   = 15'h000d;
    localparam logic [14:0] ADDR_STREAM     = 15'h0010;
    localparam logic [14:0] ADDR_SYSREF     = 15'h0029;
    localparam logic [14:0] ADDR_CLKOPT     = 15'h002a;

    // reset values
    localparam logic [7:0] RST_SERIAL_CFG = 8'h30;
    localparam logic [7:0] RST_OPMODE     = 8'h00;
    localparam logic [7:0] RST_STREAM     = 8'h00;
    localparam logic [7:0] RST_SYSREF     = 8'h80;
    localparam logic [7:0] RST_CLKOPT     = 8'h00;

    // reserved field masks
    localparam logic [7:0] RSV_SERIAL_CFG = 8'h4f;
    localparam logic [7:0] RSV_OPMODE     = 8'hfc;
    localparam logic [7:0] RSV_STREAM     = 8'hfe;
    localparam logic [7:0] RSV_SYSREF     = 8'h80;
    localparam logic [7:0] RSV_CLKOPT     = 8'hf8;

    // field positions
    localparam int CFG_SOFT_RESET_BIT = 7;
    localparam int CFG_ASCEND_BIT     = 5;
    localparam int CFG_SEP_OUT_BIT    = 4;
    localparam int STREAM_HOLD_BIT    = 0;
    localparam int SYS_PROC_BIT       = 6;
    localparam int SYS_RECV_BIT       = 5;
    localparam int SYS_FINE_BIT       = 4;

    // operating mode codes
    localparam logic [1:0] MODE_NORMAL     = 2'h0;
    localparam logic [1:0] MODE_POWER_DOWN = 2'h3;

    // serial frame: r/w bit, 15 address bits, then data bytes
    localparam logic [4:0] HDR_LAST   = 5'h0f;
    localparam logic [4:0] DATA_FIRST = 5'h10;
    localparam logic [4:0] FRAME_LAST = 5'h17;
    localparam int         SCLK_HALF_CYC = 4;

    // soft reset settling
    localparam int CLK_PERIOD_NS   = 4;
    localparam int SOFT_RESET_NS   = 750;
    localparam int DEV_RESET_CYC   = SOFT_RESET_NS / CLK_PERIOD_NS;
    localparam int HOST_SETTLE_CYC =
        (SOFT_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // host controller registers on the system bus
    localparam logic [7:0] HOST_CMD_OFS  = 8'h00;
    localparam logic [7:0] HOST_STAT_OFS = 8'h04;
    localparam int CMD_ADDR_LSB    = 8;
    localparam int CMD_READ_BIT    = 24;
    localparam int STAT_BUSY_BIT   = 0;
    localparam int STAT_SETTLE_BIT = 1;
    localparam int STAT_RDATA_LSB  = 8;

    typedef enum logic [1:0] {
        HS_IDLE   = 2'b00,
        HS_SHIFT  = 2'b01,
        HS_SETTLE = 2'b10
    } scr_host_state_t;

endpackage

// ==== logic/scr_spi_if.sv ====
/*
 * Four-wire serial link between the host controller and the register
 * bank. Assumes both ends run on the same system clock.
 */
`timescale 1ns/1ps
interface scr_spi_if;
    logic sclk;
    logic cs_n;
    logic sdi;
    logic sdo;

    modport host (output sclk, output cs_n, output sdi, input sdo);
    modport dev  (input sclk, input cs_n, input sdi, output sdo);
endinterface

// ==== logic/scr_timer.sv ====
/*
 * Down-counting interval timer: busy for COUNT cycles after start.
 * Assumes start is a synchronous pulse.
 */
`timescale 1ns/1ps
module scr_timer #(
    parameter int COUNT = 1
) (
    // clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // control
    input  wire logic start,
    output logic      busy
);
    localparam int             W    = $clog2(COUNT + 1);
    localparam logic [W-1:0]   LAST = W'(COUNT);

    logic [W-1:0] cnt_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= '0;
        end else if (start) begin
            cnt_q <= LAST;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    assign busy = (cnt_q != '0);
endmodule

// ==== verif/scr_chk.sv ====
/*
 * Wire checks on the serial link between host controller and bank.
 * Assumes it sits beside the scr_spi_if that joins the two ends.
 */
`timescale 1ns/1ps
module scr_chk
    import scr_pkg::*;
#(
    parameter logic [15:0] MAKER_CODE = 16'h5a3c
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // serial link
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdi,
    input wire logic sdo
);
    logic        sclk_q;
    logic        cs_q;
    logic        seen_q;
    logic [4:0]  cnt_q;
    logic [23:0] sh_q;
    logic [7:0]  rq_q;
    logic [7:0]  gap_q;
    logic        fe;
    logic        wr_end;
    logic [14:0] adr;
    assign fe     = cs_n & ~cs_q;
    assign wr_end = fe & ~sh_q[23];
    assign adr    = sh_q[22:8];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sclk_q <= 1'b0;
            cs_q   <= 1'b1;
        end else begin
            sclk_q <= sclk;
            cs_q   <= cs_n;
        end
    end
    // frame capture on each sclk rise
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= 5'h00;
            sh_q  <= 24'h000000;
            rq_q  <= 8'h00;
        end else if (cs_n) begin
            cnt_q <= 5'h00;
        end else if (sclk && !sclk_q) begin
            cnt_q <= cnt_q + 5'h01;
            sh_q  <= {sh_q[22:0], sdi};
            rq_q  <= {rq_q[6:0], sdo};
        end
    end
    // receiver enable written at some point since the last soft reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            seen_q <= 1'b0;
        end else if (wr_end && adr == ADDR_SERIAL_CFG && sh_q[7]) begin
            seen_q <= 1'b0;
        end else if (wr_end && adr == ADDR_SYSREF && sh_q[SYS_RECV_BIT]) begin
            seen_q <= 1'b1;
        end
    end
    // quiet interval after a soft reset frame
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gap_q <= 8'h00;
        end else if (wr_end && adr == ADDR_SERIAL_CFG && sh_q[7]) begin
            gap_q <= 8'(HOST_SETTLE_CYC - 1);
        end else if (gap_q != 8'h00) begin
            gap_q <= gap_q - 8'h01;
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sclk_idle_a: assert property (cs_n |-> !sclk)
        else $error("sclk moves outside a frame");
    sdo_idle_a: assert property (cs_n [*3] |-> !sdo)
        else $error("sdo driven outside a frame");
    sclk_high_a: assert property (
        $rose(sclk) |-> sclk [*4] ##1 !sclk)
        else $error("sclk high phase not four cycles");
    sdi_stable_a: assert property (sclk && !cs_n |-> $stable(sdi))
        else $error("sdi changed while sclk high");
    frame_len_a: assert property (fe |-> cnt_q == 5'h18)
        else $error("frame length not 24 bits");
    settle_gap_a: assert property (gap_q != 8'h00 |-> cs_n)
        else $error("frame started during soft reset");
    sysref_rsv_a: assert property (
        wr_end && adr == ADDR_SYSREF |-> sh_q[7])
        else $error("reserved sysref bit not written as one");
    opmode_rsv_a: assert property (
        wr_end && adr == ADDR_OPMODE |-> sh_q[7:2] == 6'h00)
        else $error("reserved mode bits not written as zero");
    proc_order_a: assert property (
        wr_end && adr == ADDR_SYSREF && sh_q[SYS_PROC_BIT] |-> seen_q)
        else $error("processor enabled before receiver");
    cfg_read_a: assert property (
        fe && sh_q[23] && adr == ADDR_SERIAL_CFG |-> rq_q[7:4] ==? 4'b0?_?1)
        else $error("config read shows wrong fixed bits");
    maker_read_a: assert property (
        fe && sh_q[23] && adr == ADDR_MAKER_LO |-> rq_q == MAKER_CODE[7:0])
        else $error("maker code low byte wrong");
endmodule

// ==== verif/spi_config_and_sysref_ctrl_regs_test.sv ====
/*
 * Drives the host controller over AHB-Lite and checks the register bank
 * through the serial link and its control outputs.
 * Assumes scr_host and scr_dev are joined by one scr_spi_if.
 */
`timescale 1ns/1ps
module spi_config_and_sysref_ctrl_regs_test
    import scr_pkg::*;
;
    localparam logic [15:0] MK = 16'h5a3c; // arbitrary maker code
    typedef struct packed {
        logic        rd;
        logic [14:0] a;
        logic [7:0]  d;
        logic [7:0]  q;
        logic [7:0]  o;
    } scr_row_t;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic        sysref_in = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hrdata;
    logic        hreadyout, hresp, sysref_event, recv, proc, fine, pd, crst;
    logic [3:0]  dly;
    logic [2:0]  clkopt;
    logic        seen_rst = 1'b0;
    logic [7:0]  q;
    logic [31:0] w;
    int          failures = 0;
    int          num_checks = 0;
    scr_row_t    rows [19] = '{
        '{1'b1, 15'h00, 8'h00, 8'h30, 8'h00},
        '{1'b1, 15'h0c, 8'h00, MK[7:0], 8'h00},
        '{1'b1, 15'h0d, 8'h00, MK[15:8], 8'h00},
        '{1'b0, 15'h0c, 8'hff, 8'h00, 8'h00},
        '{1'b1, 15'h0c, 8'h00, MK[7:0], 8'h00},
        '{1'b0, 15'h02, 8'h03, 8'h00, 8'h01},
        '{1'b1, 15'h02, 8'h00, 8'h03, 8'h01},
        '{1'b0, 15'h02, 8'h01, 8'h00, 8'h00},
        '{1'b0, 15'h02, 8'h02, 8'h00, 8'h00},
        '{1'b1, 15'h29, 8'h00, 8'h80, 8'h00},
        '{1'b0, 15'h29, 8'h20, 8'h00, 8'h80},
        '{1'b0, 15'h29, 8'h7a, 8'h00, 8'hf4},
        '{1'b1, 15'h29, 8'h00, 8'hfa, 8'hf4},
        '{1'b0, 15'h2a, 8'h05, 8'h00, 8'hf4},
        '{1'b1, 15'h2a, 8'h00, 8'h05, 8'hf4},
        '{1'b0, 15'h10, 8'hff, 8'h00, 8'hf4},
        '{1'b1, 15'h10, 8'h00, 8'h01, 8'hf4},
        '{1'b0, 15'h00, 8'h00, 8'h00, 8'hf4},
        '{1'b1, 15'h00, 8'h00, 8'h10, 8'hf4}};

    scr_spi_if spi ();
    scr_host i_scr_host (.spi(spi.host), .hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp));
    scr_dev #(.MAKER_CODE(MK)) i_scr_dev (.spi(spi.dev), .hclk(hclk),
        .hresetn(hresetn), .sysref_in(sysref_in),
        .sysref_event(sysref_event), .sysref_receiver_enable(recv),
        .sysref_processor_enable(proc), .sysref_fine_step(fine),
        .sysref_delay_choice(dly), .chip_reset(crst), .power_down(pd),
        .clock_input_options(clkopt));
    scr_chk #(.MAKER_CODE(MK)) i_scr_chk (.hclk(hclk), .hresetn(hresetn),
        .sclk(spi.sclk), .cs_n(spi.cs_n), .sdi(spi.sdi), .sdo(spi.sdo));

    always #2 hclk = ~hclk;
    always @(posedge hclk) if (crst === 1'b1) seen_rst <= 1'b1;

    task automatic end_sim;
        if (failures == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, g);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic ahb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= wr;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask
    // one serial frame through the command register, then poll busy
    task automatic cmd(input logic rd, input logic [14:0] a,
                       input logic [7:0] d, output logic [7:0] rq);
        logic [31:0] s;
        ahb(1'b1, HOST_CMD_OFS, {7'h0, rd, 1'b0, a, d}, s);
        @(posedge hclk);
        do ahb(1'b0, HOST_STAT_OFS, 32'h0, s);
        while (s[STAT_BUSY_BIT] !== 1'b0);
        rq = s[15:8];
    endtask
    task automatic strobe(output logic [31:0] n);
        sysref_in <= 1'b1;
        n = 32'h0;
        repeat (8) begin
            @(posedge hclk);
            if (sysref_event === 1'b1) n++;
        end
        sysref_in <= 1'b0;
    endtask

    initial begin
        repeat (30000) @(posedge hclk);
        failures++;
        end_sim;
    end

    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        foreach (rows[i]) begin
            cmd(rows[i].rd, rows[i].a, rows[i].d, q);
            if (rows[i].rd) chk("read", {24'h0, rows[i].q},
                {24'h0, q});
            chk("outputs", {24'h0, rows[i].o},
                {24'h0, recv, proc, fine, dly, pd});
        end
        chk("clock options", 32'h5, {29'h0, clkopt});
        strobe(w);
        chk("events enabled", 32'h1, w);
        cmd(1'b0, ADDR_SERIAL_CFG, 8'h80, q);
        chk("chip reset", 32'h1, {31'h0, seen_rst});
        chk("outputs", 32'h0,
            {24'h0, recv, proc, fine, dly, pd});
        cmd(1'b1, ADDR_SERIAL_CFG, 8'h00, q);
        chk("config", {24'h0, RST_SERIAL_CFG}, 32'(q));
        cmd(1'b1, ADDR_SYSREF, 8'h00, q);
        chk("sysref reg", {24'h0, RST_SYSREF}, {24'h0, q});
        cmd(1'b1, ADDR_OPMODE, 8'h00, q);
        chk("mode reg", {24'h0, RST_OPMODE}, {24'h0, q});
        strobe(w);
        chk("events disabled", 32'h0, w);
        cmd(1'b0, ADDR_OPMODE, 8'h03, q);
        chk("power down", 32'h1, {31'h0, pd});
        hresetn <= 1'b0;
        @(posedge hclk);
        hresetn <= 1'b1;
        chk("power down", 32'h0, {31'h0, pd});
        ahb(1'b1, 8'h08, 32'hffffffff, w);
        ahb(1'b0, 8'h08, 32'h0, w);
        chk("unmapped", 32'h0, w);
        end_sim;
    end
endmodule
